// ==== dad_pkg.sv ====
// Package for the debug APB address decoder: map constants and carrier types
package dad_pkg;

  // ==========================================================================
  // Address space
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CORES = 8;
  localparam int unsigned NUM_PE_SLOTS = 16;

  // ==========================================================================
  // Newer layout: 1MB per element, 64KB pages, bottom 4KB used
  localparam int unsigned PE_REGION_LSB = 20;
  localparam int unsigned PAGE64_LSB = 16;
  localparam int unsigned PAGE4_LSB = 12;
  localparam logic [3:0] PG_ROM = 4'h0;
  localparam logic [3:0] PG_DEBUG = 4'h1;
  localparam logic [3:0] PG_CTI = 4'h2;
  localparam logic [3:0] PG_PMU = 4'h3;
  localparam logic [3:0] PG_TRACE = 4'h4;
  localparam logic [3:0] PG_ELA = 4'hc;
  localparam logic [3:0] PG_CL_ELA = 4'hd;
  localparam logic [3:0] PG_CL_CTI = 4'he;
  localparam logic [3:0] PG_ACT = 4'hf;

  // ==========================================================================
  // Older layout: packed 4KB pages, groups of four elements per 128KB
  localparam logic [5:0] OLD_ROM = 6'h00;
  localparam logic [5:0] OLD_CL_ELA = 6'h01;
  localparam logic [5:0] OLD_CL_CTI = 6'h02;
  // Group-relative 4KB slot bases (slot bits [4:2]), element in bits [1:0]
  localparam logic [2:0] OLD_G_DEBUG = 3'h1;
  localparam logic [2:0] OLD_G_ELA = 3'h2;
  localparam logic [2:0] OLD_G_PMU = 3'h3;
  localparam logic [2:0] OLD_G_CTI = 3'h5;
  localparam logic [2:0] OLD_G_ACT = 3'h6;
  localparam logic [2:0] OLD_G_TRACE = 3'h7;

  // ==========================================================================
  // Component kinds
  typedef enum logic [3:0] {
    DAD_CMP_NONE = 4'h0,
    DAD_CMP_ROM = 4'h1,
    DAD_CMP_DEBUG = 4'h2,
    DAD_CMP_CTI = 4'h3,
    DAD_CMP_PMU = 4'h4,
    DAD_CMP_TRACE = 4'h5,
    DAD_CMP_ELA = 4'h6,
    DAD_CMP_ACT = 4'h7,
    DAD_CMP_CL_ELA = 4'h8,
    DAD_CMP_CL_CTI = 4'h9
  } dad_cmp_t;

  localparam int unsigned NUM_TARGETS = 10;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } dad_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } dad_apb_rsp_t;

  typedef struct packed {
    dad_cmp_t kind;
    logic [3:0] pe;
    logic [PAGE4_LSB-1:0] offset;
  } dad_target_t;

endpackage : dad_pkg

// ==== dad_decoder.sv ====
// Debug APB address decoder: routes each access to at most one debug component
// Function
// - Every address selects at most one component from a fixed base table.
// - Newer layout: component uses only bottom 4KB of its 64KB page.
// - Upper 60KB of each page is reserved, never selects component.
// - Unassigned address ranges decode as reserved space.
// - Reserved ranges read as zero.
// - ROM table sits at address zero.
// - Element zero debug block at 0x010000.
// - Each element repeats the pattern one 1MB step higher.
// - Activity monitor at last page of each element region.
// - Cluster analyzer only at page thirteen of element zero region.
// - Cluster cross-trigger only at page fourteen of element zero region.
// - Element equals core number; only elements below CORES (at most eight) decode.
// - 64KB-page layout applies when the newer map option is selected.
// - Activity monitor id/device registers are unimplemented, read zero.
// - Older option uses packed 4KB pages, cluster blocks above ROM.
`timescale 1ns/100ps

module dad_decoder #(
  parameter int unsigned CORES = dad_pkg::NUM_CORES,
  // Activity monitor identification window start, in the 4KB page
  parameter logic [11:0] ACT_ID_BASE = 12'hd00
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Map option: high selects the newer 64KB-page layout
  input wire logic map_new_i,
  // Debug APB slave port from the master
  input wire dad_pkg::dad_apb_req_t up_req_i,
  output dad_pkg::dad_apb_rsp_t up_rsp_o,
  // Shared request towards components; select is one-hot, or all zero for reserved space
  output logic [dad_pkg::NUM_TARGETS-1:0] dn_sel_o,
  output logic [3:0] dn_pe_o,
  output logic [11:0] dn_addr_o,
  output logic dn_penable_o,
  output logic dn_pwrite_o,
  output logic [dad_pkg::DATA_W-1:0] dn_pwdata_o,
  // Answer from the selected component
  input wire logic dn_pready_i,
  input wire logic [dad_pkg::DATA_W-1:0] dn_prdata_i,
  input wire logic dn_pslverr_i
);
  import dad_pkg::*;

  // Elaboration guard: CORES must lie in 1..NUM_CORES (eight), though the four-bit element field could name sixteen
  if (CORES < 1 || CORES > NUM_CORES) begin : g_bad_cores
    $error("dad_decoder: CORES must be 1..8");
  end

  // ==========================================================================
  // Decode
  // Purely combinational, so a decode adds no wait state to the bus.
  function automatic dad_target_t decode(input logic [ADDR_W-1:0] a, input logic nw);
    dad_target_t t;
    logic [3:0] pe;
    logic [3:0] pg;
    logic [5:0] slot;
    logic [2:0] grp;
    t.kind = DAD_CMP_NONE;
    t.pe = 4'h0;
    t.offset = a[PAGE4_LSB-1:0];
    pe = a[23:20];
    pg = a[19:16];
    slot = a[17:12];
    grp = slot[4:2];
    if (nw) begin
      t.pe = pe;
      // Only the bottom 4KB of a page is decoded
      if (a[15:12] == 4'h0) begin
        case (pg)
          PG_ROM: t.kind = (pe == 4'h0) ? DAD_CMP_ROM : DAD_CMP_NONE;
          PG_DEBUG: t.kind = DAD_CMP_DEBUG;
          PG_CTI: t.kind = DAD_CMP_CTI;
          PG_PMU: t.kind = DAD_CMP_PMU;
          PG_TRACE: t.kind = DAD_CMP_TRACE;
          PG_ELA: t.kind = DAD_CMP_ELA;
          PG_CL_ELA: t.kind = (pe == 4'h0) ? DAD_CMP_CL_ELA : DAD_CMP_NONE;
          PG_CL_CTI: t.kind = (pe == 4'h0) ? DAD_CMP_CL_CTI : DAD_CMP_NONE;
          PG_ACT: t.kind = DAD_CMP_ACT;
          default: t.kind = DAD_CMP_NONE;
        endcase
      end
      // Cluster blocks belong to element zero's region only
      if (t.kind == DAD_CMP_ROM || t.kind == DAD_CMP_CL_ELA || t.kind == DAD_CMP_CL_CTI) begin
        t.pe = 4'h0;
      end
    end else begin
      // Packed layout only spans the low 512KB
      if (a[23:19] == 5'h00) begin
        if (a[18:12] == {1'b0, OLD_ROM}) begin
          t.kind = DAD_CMP_ROM;
        end else if (a[18:12] == {1'b0, OLD_CL_ELA}) begin
          t.kind = DAD_CMP_CL_ELA;
        end else if (a[18:12] == {1'b0, OLD_CL_CTI}) begin
          t.kind = DAD_CMP_CL_CTI;
        end else begin
          t.pe = {a[18:17], slot[1:0]};
          case (grp)
            OLD_G_DEBUG: t.kind = DAD_CMP_DEBUG;
            OLD_G_ELA: t.kind = DAD_CMP_ELA;
            OLD_G_PMU: t.kind = DAD_CMP_PMU;
            OLD_G_CTI: t.kind = DAD_CMP_CTI;
            OLD_G_ACT: t.kind = DAD_CMP_ACT;
            OLD_G_TRACE: t.kind = DAD_CMP_TRACE;
            default: t.kind = DAD_CMP_NONE;
          endcase
          if (t.kind == DAD_CMP_NONE) begin
            t.pe = 4'h0;
          end
        end
      end
    end
    // Per-element blocks beyond the built cores stay unmapped
    if (t.kind inside {DAD_CMP_DEBUG, DAD_CMP_CTI, DAD_CMP_PMU, DAD_CMP_TRACE,
                       DAD_CMP_ELA, DAD_CMP_ACT}) begin
      if (32'(t.pe) >= CORES) begin
        t.kind = DAD_CMP_NONE;
        t.pe = 4'h0;
      end
    end
    // Identification block of the activity monitor is not built
    if (t.kind == DAD_CMP_ACT && t.offset >= ACT_ID_BASE) begin
      t.kind = DAD_CMP_NONE;
      t.pe = 4'h0;
    end
    return t;
  endfunction : decode

  // ==========================================================================
  // State
  // Read data is captured in a flop, but up_rsp_o.prdata does not use it; the master sees the unregistered value.
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } dad_state_t;

  dad_state_t state_reg;
  dad_state_t state_next;
  dad_target_t tgt;
  logic hit;
  logic access;
  logic done;

  always_comb begin
    tgt = decode(up_req_i.paddr, map_new_i);
    hit = (tgt.kind != DAD_CMP_NONE);
    access = up_req_i.psel & up_req_i.penable;
    // Reserved space answers at once so the master never stalls on it
    done = access & (hit ? dn_pready_i : 1'b1);
    state_next = state_reg;
    if (done && !up_req_i.pwrite) begin
      state_next.rdata = hit ? dn_prdata_i : '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    dn_sel_o = '0;
    if (up_req_i.psel && hit) begin
      dn_sel_o[tgt.kind] = 1'b1;
    end
    dn_pe_o = tgt.pe;
    dn_addr_o = tgt.offset;
    dn_penable_o = up_req_i.penable & hit;
    // Writes to reserved space go nowhere
    dn_pwrite_o = up_req_i.pwrite & hit;
    dn_pwdata_o = up_req_i.pwdata;
    up_rsp_o.pready = ~access | done;
    // Read data passes through in the completing cycle; reserved reads give zero
    up_rsp_o.prdata = (done && !up_req_i.pwrite && hit) ? dn_prdata_i : '0;
    up_rsp_o.pslverr = done & hit & dn_pslverr_i;
  end

endmodule : dad_decoder

// ==== dad_checker.sv ====
// Port-level assertions for the debug APB address decoder
`timescale 1ns/100ps
module dad_checker import dad_pkg::*; #(
  parameter int unsigned CORES = 8,
  parameter logic [11:0] ACT_ID_BASE = 12'hd00
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic map_new_i,
  input wire dad_pkg::dad_apb_req_t up_req_i,
  input wire dad_pkg::dad_apb_rsp_t up_rsp_o,
  input wire logic [9:0] dn_sel_o,
  input wire logic [3:0] dn_pe_o,
  input wire logic dn_penable_o,
  input wire logic dn_pready_i,
  input wire logic [31:0] dn_prdata_i
);
  // ====
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [23:0] a = up_req_i.paddr;
  wire logic ps = up_req_i.psel;
  wire logic acc = ps && up_req_i.penable;
  a_sel_one_hot: assert property (ps |-> $onehot0(dn_sel_o) && !dn_sel_o[0])
    else $error("select not one-hot");
  a_upper_page_res: assert property (map_new_i && ps && a[15:12] != 4'h0 |-> dn_sel_o == 10'h000)
    else $error("upper page selected a component");
  a_rom_base: assert property (map_new_i && ps && a[23:12] == 12'h000 |-> dn_sel_o == 10'h002)
    else $error("rom table not at zero");
  a_res_reads_zero: assert property (acc && dn_sel_o == 10'h000 |->
    up_rsp_o.pready && up_rsp_o.prdata == 32'h0 && !up_rsp_o.pslverr)
    else $error("reserved access not zero-wait zero data");
  a_write_dropped: assert property (dn_sel_o == 10'h000 |-> !dn_penable_o)
    else $error("enable passed to no component");
  a_core_limit: assert property (map_new_i && ps && a[23:20] >= CORES |-> dn_sel_o == 10'h000)
    else $error("element beyond core count selected");
  a_elem_number: assert property (map_new_i && ps && (dn_sel_o & 10'h0fc) != 10'h000 |->
    dn_pe_o == a[23:20])
    else $error("element number wrong");
  a_act_page: assert property (map_new_i && ps && a[23:20] < CORES && a[19:12] == 8'hf0 &&
    a[11:0] < ACT_ID_BASE |-> dn_sel_o[7])
    else $error("activity monitor not selected");
  a_old_cluster: assert property (!map_new_i && ps && a[23:12] == 12'h001 |-> dn_sel_o[8])
    else $error("packed layout cluster analyzer missing");
  a_wait_pass: assert property (acc && dn_sel_o != 10'h000 && !dn_pready_i ##1 acc && $stable(a)
    |-> up_rsp_o.pready == dn_pready_i)
    else $error("wait state not passed through");
  c_reserved: cover property (acc && dn_sel_o == 10'h000);
  c_act: cover property (acc && dn_sel_o[7] && dn_pready_i);
  c_old: cover property (acc && !map_new_i && dn_sel_o != 10'h000);
endmodule : dad_checker
bind dad_decoder dad_checker #(.CORES(CORES), .ACT_ID_BASE(ACT_ID_BASE)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .map_new_i(map_new_i), .up_req_i(up_req_i),
  .up_rsp_o(up_rsp_o), .dn_sel_o(dn_sel_o), .dn_pe_o(dn_pe_o), .dn_penable_o(dn_penable_o),
  .dn_pready_i(dn_pready_i), .dn_prdata_i(dn_prdata_i));

// ==== dad_comp_model.sv ====
// Component-side responder: waits addr[1:0]+1 cycles, then answers
`timescale 1ns/100ps
module dad_comp_model (
  input wire logic clk_i,
  input wire logic [9:0] sel_i,
  input wire logic [3:0] pe_i,
  input wire logic [11:0] addr_i,
  input wire logic penable_i,
  output logic pready_o,
  output logic [31:0] prdata_o
);
  // ====
  // Slow and prompt answers; data is inverted while not ready
  logic [1:0] cnt;
  initial begin
    pready_o = 1'b0;
    cnt = 2'h0;
  end
  assign prdata_o = pready_o ? {6'h29, sel_i, pe_i, addr_i} : ~{6'h29, sel_i, pe_i, addr_i};
  always @(posedge clk_i) begin
    if (|sel_i && penable_i && !pready_o) begin
      if (cnt == addr_i[1:0]) pready_o <= 1'b1;
      else cnt <= cnt + 2'h1;
    end else begin
      pready_o <= 1'b0;
      cnt <= 2'h0;
    end
  end
endmodule : dad_comp_model

// ==== dad_decoder_bench.sv ====
// Self-checking bench: random addresses against a reference map
`timescale 1ns/100ps
module dad_decoder_bench;
  import dad_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, map_new_i = 1'b1, rdy;
  dad_apb_req_t rq = '0;
  dad_apb_rsp_t rs;
  logic [9:0] sel;
  logic [3:0] pe;
  logic [11:0] ad;
  logic [31:0] rd;
  logic pen;
  logic perr = 1'b0;
  logic pwr;
  logic [31:0] pwd;
  int err_count = 0, n_tests = 0, cyc = 0;
  logic [31:0] x = 32'd38;
  always #25 mclk_i = ~mclk_i;
  dad_decoder dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .map_new_i(map_new_i),
    .up_req_i(rq), .up_rsp_o(rs), .dn_sel_o(sel), .dn_pe_o(pe), .dn_addr_o(ad),
    .dn_penable_o(pen), .dn_pwrite_o(pwr), .dn_pwdata_o(pwd), .dn_pready_i(rdy),
    .dn_prdata_i(rd), .dn_pslverr_i(perr));
  dad_comp_model u_cmp (.clk_i(mclk_i), .sel_i(sel), .pe_i(pe), .addr_i(ad),
    .penable_i(pen), .pready_o(rdy), .prdata_o(rd));
  // ====
  // Helpers
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  function automatic void exp_map(input logic nw, input logic [23:0] a, output int k, output int p);
    int s;
    k = 0;
    p = 0;
    if (nw) begin
      p = a[23:20];
      case (a[19:16])
        0: k = (p == 0) ? 1 : 0;
        1: k = 2;
        2: k = 3;
        3: k = 4;
        4: k = 5;
        12: k = 6;
        13: k = (p == 0) ? 8 : 0;
        14: k = (p == 0) ? 9 : 0;
        15: k = 7;
        default: k = 0;
      endcase
      if (a[15:12] != 4'h0) k = 0;
    end else if (a < 24'h080000) begin
      s = a[16:12];
      p = a[18:17] * 4 + s % 4;
      case (s / 4)
        0: k = (a[18:12] == 0) ? 1 : (a[18:12] < 3) ? s + 7 : 0;
        1: k = 2;
        2: k = 6;
        3: k = 4;
        5: k = 3;
        6: k = 7;
        7: k = 5;
        default: k = 0;
      endcase
    end
    if (k == 7 && a[11:0] >= 12'hd00) k = 0;
    if (k > 1 && k < 8 && p >= 8) k = 0;
    if (k < 2 || k > 7) p = 0;
  endfunction : exp_map
  task automatic xfer(input logic nw, input logic [23:0] a, input logic w);
    int k, p, n;
    exp_map(nw, a, k, p);
    @(negedge mclk_i);
    map_new_i = nw;
    rq = '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: xs()};
    // Component error follows an address bit; reserved space must never show it
    perr = a[2];
    @(posedge mclk_i);
    chk(pwr === (w && k != 0) && pwd === rq.pwdata, "write path");
    chk(sel === ((k != 0) ? 10'h001 << k : 10'h000), "select");
    if (k != 0) chk(pe === 4'(p) && ad === a[11:0], "element/offset");
    @(negedge mclk_i);
    rq.penable = 1'b1;
    n = 0;
    @(posedge mclk_i);
    while (rs.pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge mclk_i);
    end
    chk(n == ((k != 0) ? a[1:0] + 1 : 0) && rs.pslverr === (k != 0 && a[2]), "ready/err");
    if (!w) chk(rs.prdata === ((k != 0) ? {6'h29, 10'h001 << k, 4'(p), a[11:0]} : 32'h0),
      "read data");
    @(negedge mclk_i);
    rq.psel = 1'b0;
    rq.penable = 1'b0;
  endtask : xfer
  // ====
  // Main sequence; master keeps to the bottom 4KB of a 64KB page only half the time on purpose
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] r;
    logic [23:0] a;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i) reset_n_i = 1'b1;
    xfer(1'b1, 24'h000000, 1'b0);
    xfer(1'b1, 24'h010000, 1'b0);
    xfer(1'b1, 24'h1d0000, 1'b0);
    xfer(1'b1, 24'h0e0000, 1'b1);
    for (int i = 0; i < 600; i++) begin
      r = xs();
      a = r[23:0];
      if (r[24]) a[15:12] = 4'h0;
      if (i >= 300 && r[25]) a[23:19] = 5'h00;
      xfer(i < 300, a, r[26]);
    end
    end_sim();
  end
endmodule : dad_decoder_bench
